// ==== design/exec_pkg.sv ====
// Shared constants and types of the integer execution unit
`default_nettype none

package exec_pkg;

  // ----------------------------------------------------------------
  // Datapath geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int REG_COUNT = 32;
  localparam int IDX_W = 5;
  localparam int SHAMT_W = 5;
  localparam int LEAD_W = 6;
  localparam int LANE_W = 2;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int MUL_NARROW_W = 16;
  localparam int BR_SHIFT = 2;

  // ----------------------------------------------------------------
  // Addresses and byte enables
  // ----------------------------------------------------------------
  localparam logic [WORD_W-1:0] PC_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] PC_STEP = 32'h0000_0004;
  localparam logic [BE_W-1:0] BE_BYTE = 4'h1;
  localparam logic [BE_W-1:0] BE_HALF = 4'h3;
  localparam logic [BE_W-1:0] BE_WORD = 4'hf;

  // ----------------------------------------------------------------
  // Divider early-in widths and step counts
  // ----------------------------------------------------------------
  localparam int DIV_W_8 = 8;
  localparam int DIV_W_16 = 16;
  localparam int DIV_W_24 = 24;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] DIV_STEPS_8 = 6'h0b;
  localparam logic [CNT_W-1:0] DIV_STEPS_16 = 6'h12;
  localparam logic [CNT_W-1:0] DIV_STEPS_24 = 6'h19;
  localparam logic [CNT_W-1:0] DIV_STEPS_32 = 6'h20;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOR, OP_SLL, OP_SRL, OP_SRA,
    OP_SLT, OP_SLTU, OP_CNT_ZEROS, OP_CNT_ONES, OP_LOAD, OP_STORE, OP_BEQ, OP_BNE,
    OP_BLTZ, OP_BGEZ, OP_JUMP, OP_JR, OP_MULT, OP_DIV, OP_MFHI, OP_MFLO
  } op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} size_t;

endpackage

`default_nettype wire

// ==== design/register_bank.sv ====
// Thirty-two word register bank, two read ports and one write port
`default_nettype none

module register_bank #(
  parameter int ENTRIES = exec_pkg::REG_COUNT
) (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic [exec_pkg::IDX_W-1:0] ra_idx_i,
  input wire logic [exec_pkg::IDX_W-1:0] rb_idx_i,
  output logic [exec_pkg::WORD_W-1:0] ra_data_o,
  output logic [exec_pkg::WORD_W-1:0] rb_data_o,
  input wire logic we_i,
  input wire logic [exec_pkg::IDX_W-1:0] wr_idx_i,
  input wire logic [exec_pkg::WORD_W-1:0] wr_data_i
);
  import exec_pkg::*;

  logic [WORD_W-1:0] general_register_entries [ENTRIES];

  // Entry zero always reads zero
  always_comb begin
    ra_data_o = (ra_idx_i == '0) ? '0 : general_register_entries[ra_idx_i];
    rb_data_o = (rb_idx_i == '0) ? '0 : general_register_entries[rb_idx_i];
  end

  always_ff @(posedge clk_i) begin
    if (en_i && we_i && wr_idx_i != '0) begin
      general_register_entries[wr_idx_i] <= wr_data_i;
    end
  end

endmodule // register_bank

`default_nettype wire

// ==== design/mul_div_unit.sv ====
// Multiply and early-in iterative divide unit with HI and LO results
`default_nettype none

module mul_div_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic start_i,
  input wire logic is_div_i,
  input wire logic signed_i,
  input wire logic [exec_pkg::WORD_W-1:0] a_i,
  input wire logic [exec_pkg::WORD_W-1:0] b_i,
  output logic mul_ready_o,
  output logic busy_o,
  output logic [exec_pkg::WORD_W-1:0] hi_o,
  output logic [exec_pkg::WORD_W-1:0] lo_o
);
  import exec_pkg::*;

  typedef enum {MD_IDLE, MD_MUL2, MD_DIV} md_state_t;

  // Value fits in w bits, sign or zero extended
  function automatic logic fits(input logic [WORD_W-1:0] v, input int w, input logic sgn);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < WORD_W; i++) begin
      if (i >= w && v[i] != (sgn & v[w-1])) ok = 1'b0;
    end
    return ok;
  endfunction

  md_state_t state_r, state_nxt;
  logic [2*WORD_W-1:0] prod_r, prod_nxt;
  logic [WORD_W-1:0] rem_r, rem_nxt, quo_r, quo_nxt, dvs_r, dvs_nxt;
  logic [WORD_W-1:0] hi_r, hi_nxt, lo_r, lo_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic negq_r, negq_nxt, negr_r, negr_nxt;
  logic sa, sb;
  logic signed [WORD_W:0] ax, bx;
  logic signed [2*WORD_W+1:0] pfull;
  logic [WORD_W-1:0] a_abs, b_abs, q_step;
  logic [WORD_W:0] rem_sh;
  logic [CNT_W-1:0] steps;

  assign mul_ready_o = (state_r == MD_IDLE);
  assign busy_o = (state_r != MD_IDLE);
  assign hi_o = hi_r;
  assign lo_o = lo_r;

  always_comb begin
    state_nxt = state_r;
    prod_nxt = prod_r;
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    dvs_nxt = dvs_r;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    cnt_nxt = cnt_r;
    negq_nxt = negq_r;
    negr_nxt = negr_r;
    sa = signed_i & a_i[WORD_W-1];
    sb = signed_i & b_i[WORD_W-1];
    ax = $signed({sa, a_i});
    bx = $signed({sb, b_i});
    pfull = ax * bx;
    a_abs = sa ? WORD_W'(-a_i) : a_i;
    b_abs = sb ? WORD_W'(-b_i) : b_i;
    // Early-in: dividend sign or zero extension picks the step count
    if (fits(a_i, DIV_W_8, signed_i)) steps = DIV_STEPS_8;
    else if (fits(a_i, DIV_W_16, signed_i)) steps = DIV_STEPS_16;
    else if (fits(a_i, DIV_W_24, signed_i)) steps = DIV_STEPS_24;
    else steps = DIV_STEPS_32;
    rem_sh = {rem_r, quo_r[WORD_W-1]};
    q_step = {quo_r[WORD_W-2:0], 1'b0};
    case (state_r)
      MD_IDLE: begin
        if (start_i && is_div_i) begin
          rem_nxt = '0;
          quo_nxt = a_abs << (DIV_STEPS_32 - steps);
          dvs_nxt = b_abs;
          cnt_nxt = steps;
          negq_nxt = sa ^ sb;
          negr_nxt = sa;
          state_nxt = MD_DIV;
        end else if (start_i && fits(b_i, MUL_NARROW_W, signed_i)) begin
          {hi_nxt, lo_nxt} = pfull[2*WORD_W-1:0];
        end else if (start_i) begin
          prod_nxt = pfull[2*WORD_W-1:0];
          state_nxt = MD_MUL2;
        end
      end
      MD_MUL2: begin
        {hi_nxt, lo_nxt} = prod_r;
        state_nxt = MD_IDLE;
      end
      MD_DIV: begin
        // One quotient bit per clock, restoring
        if (rem_sh >= {1'b0, dvs_r}) begin
          rem_nxt = WORD_W'(rem_sh - {1'b0, dvs_r});
          quo_nxt = q_step | WORD_W'(1);
        end else begin
          rem_nxt = rem_sh[WORD_W-1:0];
          quo_nxt = q_step;
        end
        cnt_nxt = cnt_r - CNT_W'(1);
        if (cnt_r == CNT_W'(1)) begin
          hi_nxt = negr_r ? WORD_W'(-rem_nxt) : rem_nxt;
          lo_nxt = negq_r ? WORD_W'(-quo_nxt) : quo_nxt;
          state_nxt = MD_IDLE;
        end
      end
      default: state_nxt = MD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= MD_IDLE;
      prod_r <= '0;
      rem_r <= '0;
      quo_r <= '0;
      dvs_r <= '0;
      hi_r <= '0;
      lo_r <= '0;
      cnt_r <= '0;
      negq_r <= 1'b0;
      negr_r <= 1'b0;
    end else if (en_i) begin
      state_r <= state_nxt;
      prod_r <= prod_nxt;
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      dvs_r <= dvs_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      cnt_r <= cnt_nxt;
      negq_r <= negq_nxt;
      negr_r <= negr_nxt;
    end
  end

endmodule // mul_div_unit

`default_nettype wire

// ==== design/integer_execution_unit.sv ====
// Integer execution unit: register bank, bypass, ALU, branch, load/store, multiply/divide
`default_nettype none

module integer_execution_unit #(
  parameter logic [exec_pkg::WORD_W-1:0] RESET_PC = exec_pkg::PC_RESET
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic issue_valid_i,
  output logic issue_ready_o,
  input wire exec_pkg::op_t op_i,
  input wire logic [exec_pkg::IDX_W-1:0] rs_idx_i,
  input wire logic [exec_pkg::IDX_W-1:0] rt_idx_i,
  input wire logic [exec_pkg::IDX_W-1:0] rd_idx_i,
  input wire logic use_imm_i,
  input wire logic [exec_pkg::WORD_W-1:0] imm_i,
  input wire exec_pkg::size_t size_i,
  input wire logic signed_i,
  output logic [exec_pkg::WORD_W-1:0] fetch_addr_o,
  output logic branch_taken_o,
  output logic dbus_req_o,
  output logic dbus_we_o,
  output logic [exec_pkg::WORD_W-1:0] dbus_addr_o,
  output logic [exec_pkg::WORD_W-1:0] dbus_wdata_o,
  output logic [exec_pkg::BE_W-1:0] dbus_be_o,
  input wire logic [exec_pkg::WORD_W-1:0] dbus_rdata_i,
  input wire logic dbus_ack_i,
  input wire logic abort_req_i,
  output logic dbus_abort_o,
  output logic wb_valid_o,
  output logic [exec_pkg::IDX_W-1:0] wb_idx_o,
  output logic [exec_pkg::WORD_W-1:0] wb_data_o
);
  import exec_pkg::*;

  typedef enum {ST_RUN, ST_MEM} state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [LEAD_W-1:0] count_lead(input logic [WORD_W-1:0] v,
                                                   input logic ones);
    logic [LEAD_W-1:0] n;
    logic run;
    n = '0;
    run = 1'b1;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      run = run & (v[i] == ones);
      n = n + LEAD_W'(run);
    end
    return n;
  endfunction

  function automatic logic [WORD_W-1:0] bypass(input logic [IDX_W-1:0] idx,
                                               input logic [WORD_W-1:0] bank,
                                               input logic wv,
                                               input logic [IDX_W-1:0] wi,
                                               input logic [WORD_W-1:0] wd);
    return (wv && wi == idx && idx != '0) ? wd : bank;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t state_r, state_nxt;
  logic [WORD_W-1:0] pc_r, pc_nxt;
  logic taken_r, taken_nxt;
  logic req_r, req_nxt, we_r, we_nxt, abort_r, abort_nxt;
  logic [WORD_W-1:0] addr_r, addr_nxt, wdata_r, wdata_nxt;
  logic [BE_W-1:0] be_r, be_nxt;
  logic wbv_r, wbv_nxt;
  logic [IDX_W-1:0] wbi_r, wbi_nxt, ld_idx_r, ld_idx_nxt;
  logic [WORD_W-1:0] wbd_r, wbd_nxt;
  size_t ld_size_r, ld_size_nxt;
  logic ld_sgn_r, ld_sgn_nxt;

  // ----------------------------------------------------------------
  // Datapath signals
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] bank_a, bank_b, rs_val, rt_val, opb, alu_res, mem_addr;
  logic [WORD_W-1:0] br_target, seq_pc, ld_shift, ld_data, sum, diff;
  logic [SHAMT_W-1:0] shamt;
  logic [LANE_W+2:0] st_shift, ld_lane;
  logic accept, is_md, md_stall, md_start, md_ready, md_busy, cond, writes;
  logic [WORD_W-1:0] md_hi, md_lo;

  register_bank #(.ENTRIES(REG_COUNT)) u_bank (
    .clk_i(clk_i),
    .en_i(en_i),
    .ra_idx_i(rs_idx_i),
    .rb_idx_i(rt_idx_i),
    .ra_data_o(bank_a),
    .rb_data_o(bank_b),
    .we_i(wbv_r),
    .wr_idx_i(wbi_r),
    .wr_data_i(wbd_r)
  );

  mul_div_unit u_mul_div_unit (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .start_i(md_start),
    .is_div_i(op_i == OP_DIV),
    .signed_i(signed_i),
    .a_i(rs_val),
    .b_i(rt_val),
    .mul_ready_o(md_ready),
    .busy_o(md_busy),
    .hi_o(md_hi),
    .lo_o(md_lo)
  );

  // ----------------------------------------------------------------
  // Operands, arith_logic_unit, branch and address adders
  // ----------------------------------------------------------------
  always_comb begin
    rs_val = bypass(rs_idx_i, bank_a, wbv_r, wbi_r, wbd_r);
    rt_val = bypass(rt_idx_i, bank_b, wbv_r, wbi_r, wbd_r);
    opb = use_imm_i ? imm_i : rt_val;
    shamt = opb[SHAMT_W-1:0];
    sum = rs_val + opb;
    diff = rs_val - opb;
    mem_addr = rs_val + imm_i;
    seq_pc = pc_r + PC_STEP;
    br_target = seq_pc + (imm_i << BR_SHIFT);
    st_shift = {mem_addr[LANE_W-1:0], 3'b000};
    ld_lane = {addr_r[LANE_W-1:0], 3'b000};
    ld_shift = dbus_rdata_i >> ld_lane;
    case (op_i)
      OP_BEQ: cond = (rs_val == rt_val);
      OP_BNE: cond = (rs_val != rt_val);
      OP_BLTZ: cond = rs_val[WORD_W-1];
      OP_BGEZ: cond = !rs_val[WORD_W-1];
      OP_JUMP, OP_JR: cond = 1'b1;
      default: cond = 1'b0;
    endcase
    case (op_i)
      OP_ADD: alu_res = sum;
      OP_SUB: alu_res = diff;
      OP_AND: alu_res = rs_val & opb;
      OP_OR: alu_res = rs_val | opb;
      OP_XOR: alu_res = rs_val ^ opb;
      OP_NOR: alu_res = ~(rs_val | opb);
      OP_SLL: alu_res = rs_val << shamt;
      OP_SRL: alu_res = rs_val >> shamt;
      OP_SRA: alu_res = WORD_W'($signed(rs_val) >>> shamt);
      OP_SLT: alu_res = WORD_W'($signed(rs_val) < $signed(opb));
      OP_SLTU: alu_res = WORD_W'(rs_val < opb);
      OP_CNT_ZEROS: alu_res = WORD_W'(count_lead(rs_val, 1'b0));
      OP_CNT_ONES: alu_res = WORD_W'(count_lead(rs_val, 1'b1));
      OP_MFHI: alu_res = md_hi;
      OP_MFLO: alu_res = md_lo;
      default: alu_res = '0;
    endcase
    // Load aligner
    case (ld_size_r)
      SZ_BYTE: ld_data = {{(WORD_W-BYTE_W){ld_sgn_r & ld_shift[BYTE_W-1]}},
                          ld_shift[BYTE_W-1:0]};
      SZ_HALF: ld_data = {{(WORD_W-HALF_W){ld_sgn_r & ld_shift[HALF_W-1]}},
                          ld_shift[HALF_W-1:0]};
      default: ld_data = dbus_rdata_i;
    endcase
  end

  // ----------------------------------------------------------------
  // Issue control
  // ----------------------------------------------------------------
  always_comb begin
    is_md = (op_i == OP_MULT) || (op_i == OP_DIV);
    case (op_i)
      OP_MULT: md_stall = !md_ready;
      OP_DIV, OP_MFHI, OP_MFLO: md_stall = md_busy;
      default: md_stall = 1'b0;
    endcase
    issue_ready_o = en_i && (state_r == ST_RUN) && !md_stall;
    accept = issue_valid_i && issue_ready_o;
    md_start = accept && is_md;
    // Memory, branch, MULT and DIV ops write no result here
    writes = !(op_i inside {[OP_LOAD:OP_DIV]});
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    taken_nxt = 1'b0;
    req_nxt = req_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    be_nxt = be_r;
    abort_nxt = 1'b0;
    wbv_nxt = 1'b0;
    wbi_nxt = wbi_r;
    wbd_nxt = wbd_r;
    ld_idx_nxt = ld_idx_r;
    ld_size_nxt = ld_size_r;
    ld_sgn_nxt = ld_sgn_r;
    case (state_r)
      ST_RUN: begin
        if (accept) begin
          pc_nxt = seq_pc;
          if (cond) begin
            taken_nxt = 1'b1;
            pc_nxt = (op_i == OP_JUMP) ? imm_i : (op_i == OP_JR) ? rs_val : br_target;
          end
          if (writes) begin
            wbv_nxt = 1'b1;
            wbi_nxt = rd_idx_i;
            wbd_nxt = alu_res;
          end
          if (op_i == OP_LOAD || op_i == OP_STORE) begin
            req_nxt = 1'b1;
            we_nxt = (op_i == OP_STORE);
            addr_nxt = mem_addr;
            wdata_nxt = rt_val << st_shift;
            case (size_i)
              SZ_BYTE: be_nxt = BE_BYTE << mem_addr[LANE_W-1:0];
              SZ_HALF: be_nxt = BE_HALF << mem_addr[LANE_W-1:0];
              default: be_nxt = BE_WORD;
            endcase
            ld_idx_nxt = rd_idx_i;
            ld_size_nxt = size_i;
            ld_sgn_nxt = signed_i;
            state_nxt = ST_MEM;
          end
        end
      end
      ST_MEM: begin
        if (dbus_ack_i) begin
          req_nxt = 1'b0;
          state_nxt = ST_RUN;
          if (!we_r) begin
            wbv_nxt = 1'b1;
            wbi_nxt = ld_idx_r;
            wbd_nxt = ld_data;
          end
        end else if (abort_req_i) begin
          // Drop the transfer so an interrupt is not held up
          req_nxt = 1'b0;
          abort_nxt = 1'b1;
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_RUN;
      pc_r <= RESET_PC;
      taken_r <= 1'b0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      be_r <= '0;
      abort_r <= 1'b0;
      wbv_r <= 1'b0;
      wbi_r <= '0;
      wbd_r <= '0;
      ld_idx_r <= '0;
      ld_size_r <= SZ_WORD;
      ld_sgn_r <= 1'b0;
    end else if (en_i) begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      taken_r <= taken_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      be_r <= be_nxt;
      abort_r <= abort_nxt;
      wbv_r <= wbv_nxt;
      wbi_r <= wbi_nxt;
      wbd_r <= wbd_nxt;
      ld_idx_r <= ld_idx_nxt;
      ld_size_r <= ld_size_nxt;
      ld_sgn_r <= ld_sgn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fetch_addr_o = pc_r;
  assign branch_taken_o = taken_r;
  assign dbus_req_o = req_r;
  assign dbus_we_o = we_r;
  assign dbus_addr_o = addr_r;
  assign dbus_wdata_o = wdata_r;
  assign dbus_be_o = be_r;
  assign dbus_abort_o = abort_r;
  assign wb_valid_o = wbv_r;
  assign wb_idx_o = wbi_r;
  assign wb_data_o = wbd_r;

endmodule // integer_execution_unit

`default_nettype wire

// ==== verification/integer_execution_unit_props.sv ====
// Port checker of the integer execution unit
`default_nettype none

module integer_execution_unit_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic issue_valid_i,
  input wire logic issue_ready_o,
  input wire exec_pkg::op_t op_i,
  input wire logic [4:0] rd_idx_i,
  input wire logic [31:0] imm_i,
  input wire logic [31:0] fetch_addr_o,
  input wire logic branch_taken_o,
  input wire logic dbus_req_o,
  input wire logic dbus_we_o,
  input wire logic [31:0] dbus_addr_o,
  input wire logic [31:0] dbus_wdata_o,
  input wire logic [3:0] dbus_be_o,
  input wire logic dbus_ack_i,
  input wire logic abort_req_i,
  input wire logic dbus_abort_o,
  input wire logic wb_valid_o,
  input wire logic [4:0] wb_idx_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import exec_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic go;
  assign go = issue_valid_i && issue_ready_o;
  sequence s_jump_taken;
    go && op_i == OP_JUMP;
  endsequence
  sequence s_abort_done;
    !dbus_req_o && dbus_abort_o ##1 !dbus_abort_o;
  endsequence
  property p_alu_one;
    go && rd_idx_i != 5'd0 && op_i inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR}
      |=> wb_valid_o && wb_idx_o == $past(rd_idx_i);
  endproperty
  property p_fetch_step;
    go && op_i inside {OP_ADD, OP_SUB, OP_AND, OP_OR}
      |=> fetch_addr_o == $past(fetch_addr_o) + PC_STEP;
  endproperty
  property p_jump;
    s_jump_taken |=> branch_taken_o && fetch_addr_o == $past(imm_i);
  endproperty
  property p_ls_req;
    go && op_i inside {OP_LOAD, OP_STORE} |=> dbus_req_o && dbus_we_o == ($past(op_i) == OP_STORE);
  endproperty
  property p_req_hold;
    dbus_req_o && !dbus_ack_i && !abort_req_i |=> dbus_req_o && $stable(dbus_addr_o)
      && $stable(dbus_wdata_o) && $stable(dbus_be_o);
  endproperty
  property p_ack_ends;
    dbus_req_o && dbus_ack_i && en_i |=> !dbus_req_o && !dbus_abort_o;
  endproperty
  property p_load_wb;
    dbus_req_o && dbus_ack_i && en_i && !dbus_we_o |=> wb_valid_o;
  endproperty
  property p_abort;
    dbus_req_o && abort_req_i && !dbus_ack_i && en_i |=> s_abort_done;
  endproperty
  property p_one_pending;
    dbus_req_o |-> !issue_ready_o;
  endproperty
  a_alu_one: assert property (p_alu_one) else $error("alu result late");
  a_fetch_step: assert property (p_fetch_step) else $error("fetch step wrong");
  a_jump: assert property (p_jump) else $error("jump target wrong");
  a_ls_req: assert property (p_ls_req) else $error("no data request");
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  a_ack_ends: assert property (p_ack_ends) else $error("request after ack");
  a_load_wb: assert property (p_load_wb) else $error("load not written");
  a_abort: assert property (p_abort) else $error("abort wrong");
  a_one_pending: assert property (p_one_pending) else $error("issue while pending");
endmodule // integer_execution_unit_props

`default_nettype wire

// ==== verification/data_mem_model.sv ====
// Data memory model on the far side of the data bus
`default_nettype none

module data_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] be_i,
  input wire logic stall_i,
  input wire logic [31:0] dly_i,
  output logic [31:0] rdata_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [16];
  int cnt;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt <= 0;
      rdata_o <= 32'h0000_0000;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o && !stall_i && cnt >= dly_i) begin
        ack_o <= 1'b1;
        cnt <= 0;
        if (we_i) begin
          for (int i = 0; i < 4; i++) begin
            if (be_i[i]) mem[addr_i[5:2]][8*i +: 8] <= wdata_i[8*i +: 8];
          end
        end else begin
          rdata_o <= mem[addr_i[5:2]];
        end
      end else if (req_i && !ack_o) begin
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule // data_mem_model

`default_nettype wire

// ==== verification/integer_execution_unit_bench.sv ====
// Testbench of the integer execution unit
`default_nettype none

bind integer_execution_unit integer_execution_unit_props chk (
  .clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .issue_valid_i(issue_valid_i),
  .issue_ready_o(issue_ready_o), .op_i(op_i), .rd_idx_i(rd_idx_i), .imm_i(imm_i),
  .fetch_addr_o(fetch_addr_o), .branch_taken_o(branch_taken_o), .dbus_req_o(dbus_req_o),
  .dbus_we_o(dbus_we_o), .dbus_addr_o(dbus_addr_o), .dbus_wdata_o(dbus_wdata_o),
  .dbus_be_o(dbus_be_o), .dbus_ack_i(dbus_ack_i), .abort_req_i(abort_req_i),
  .dbus_abort_o(dbus_abort_o), .wb_valid_o(wb_valid_o), .wb_idx_o(wb_idx_o)
);

module integer_execution_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import exec_pkg::*;
  logic clk, rst, en, vld, ui, sg, ack, abt, stall, rdy, bt, req, we, dab, wbv;
  op_t op;
  size_t sz;
  logic [4:0] rs, rt, rd, wbi;
  logic [31:0] imm, fa, wa, wd, rdat, wbd, a, b, v;
  logic [3:0] be;
  int dly, num_errors, tests_run, nw;
  int dv[4] = '{100, 'h1234, 'h12_3456, 'h4000_0000};
  int st[4] = '{11, 18, 25, 32};

  integer_execution_unit DUT (.clk_i(clk), .rst_i(rst), .en_i(en), .issue_valid_i(vld),
    .issue_ready_o(rdy), .op_i(op), .rs_idx_i(rs), .rt_idx_i(rt), .rd_idx_i(rd),
    .use_imm_i(ui), .imm_i(imm), .size_i(sz), .signed_i(sg), .fetch_addr_o(fa),
    .branch_taken_o(bt), .dbus_req_o(req), .dbus_we_o(we), .dbus_addr_o(wa),
    .dbus_wdata_o(wd), .dbus_be_o(be), .dbus_rdata_i(rdat), .dbus_ack_i(ack),
    .abort_req_i(abt), .dbus_abort_o(dab), .wb_valid_o(wbv), .wb_idx_o(wbi),
    .wb_data_o(wbd));
  data_mem_model mem (.clk_i(clk), .rst_i(rst), .req_i(req), .we_i(we), .addr_i(wa),
    .wdata_i(wd), .be_i(be), .stall_i(stall), .dly_i(dly), .rdata_o(rdat), .ack_o(ack));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report;
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Offer one instruction, count refused edges, return after the accepting edge
  task automatic iss(input op_t o, input logic [4:0] s, t, d, input logic u,
                     input logic [31:0] m);
    op = o;
    rs = s;
    rt = t;
    rd = d;
    ui = u;
    imm = m;
    vld = 1'b1;
    nw = 0;
    @(negedge clk);
    while (!rdy && nw < 60) begin
      nw++;
      @(negedge clk);
    end
    chk(rdy, 1'b1);
    @(posedge clk);
    #1;
  endtask

  task automatic alu(input op_t o, input logic [4:0] s, t, d, input logic u,
                     input logic [31:0] m, e);
    iss(o, s, t, d, u, m);
    chk(wbv, 1'b1);
    chk(wbi, d);
    chk(wbd, e);
  endtask

  // Release the issue port and wait for the data bus to go quiet
  task automatic settle;
    vld = 1'b0;
    nw = 0;
    while ((req || wbv) && nw < 50) begin
      @(posedge clk);
      #1;
      nw++;
    end
    chk(req, 1'b0);
    if (!wbv) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic ld(input size_t z, input logic g, input logic [31:0] m, e);
    sz = z;
    sg = g;
    iss(OP_LOAD, 9, 0, 10, 1'b0, m);
    chk(wa, 32'h40 + m);
    vld = 1'b0;
    nw = 0;
    while (!wbv && nw < 50) begin
      @(posedge clk);
      #1;
      nw++;
    end
    chk(wbv, 1'b1);
    chk(wbd, e);
  endtask

  task automatic t_alu;
    a = 32'h8234_5678;
    b = 32'h0000_80f0;
    alu(OP_ADD, 0, 0, 1, 1'b1, a, a);
    alu(OP_ADD, 0, 0, 2, 1'b1, b, b);
    alu(OP_ADD, 1, 2, 3, 1'b0, 0, a + b);
    alu(OP_SUB, 3, 2, 4, 1'b0, 0, a);
    alu(OP_AND, 1, 2, 5, 1'b0, 0, a & b);
    alu(OP_OR, 1, 2, 5, 1'b0, 0, a | b);
    alu(OP_XOR, 1, 2, 5, 1'b0, 0, a ^ b);
    alu(OP_NOR, 1, 2, 5, 1'b0, 0, ~(a | b));
    alu(OP_SLT, 1, 2, 5, 1'b0, 0, 1);
    alu(OP_SLTU, 1, 2, 5, 1'b0, 0, 0);
    alu(OP_SLL, 1, 0, 5, 1'b1, 4, a << 4);
    alu(OP_SRL, 1, 0, 5, 1'b1, 4, a >> 4);
    alu(OP_SRA, 1, 0, 5, 1'b1, 4, 32'($signed(a) >>> 4));
    iss(OP_ADD, 0, 0, 0, 1'b1, a);
    alu(OP_OR, 0, 0, 6, 1'b0, 0, 0);
    alu(OP_CNT_ZEROS, 2, 0, 6, 1'b0, 0, 16);
    alu(OP_CNT_ONES, 1, 0, 6, 1'b0, 0, 1);
  endtask

  task automatic t_br;
    v = fa;
    iss(OP_BEQ, 1, 1, 0, 1'b0, 3);
    chk(bt, 1'b1);
    chk(fa, v + 16);
    v = fa;
    iss(OP_BNE, 1, 1, 0, 1'b0, 3);
    chk(bt, 1'b0);
    chk(fa, v + 4);
    v = fa;
    iss(OP_BLTZ, 1, 0, 0, 1'b0, 2);
    chk(fa, v + 12);
    iss(OP_JR, 2, 0, 0, 1'b0, 0);
    chk(fa, b);
    iss(OP_JUMP, 0, 0, 0, 1'b0, 32'h100);
    settle;
    chk(bt, 1'b0);
  endtask

  task automatic t_mem;
    dly = 2;
    alu(OP_ADD, 0, 0, 9, 1'b1, 32'h40, 32'h40);
    sz = SZ_WORD;
    iss(OP_STORE, 9, 1, 0, 1'b0, 0);
    chk({we, be, wa[7:0]}, {1'b1, BE_WORD, 8'h40});
    chk(wd, a);
    settle;
    sz = SZ_HALF;
    iss(OP_STORE, 9, 2, 0, 1'b0, 6);
    chk(be, 4'hc);
    chk(wd >> 16, {16'h0000, b[15:0]});
    settle;
    dly = 0;
    ld(SZ_BYTE, 1'b0, 1, {24'h00_0000, a[15:8]});
    ld(SZ_HALF, 1'b1, 6, {16'hffff, b[15:0]});
    ld(SZ_HALF, 1'b0, 6, {16'h0000, b[15:0]});
    ld(SZ_WORD, 1'b0, 0, a);
    stall = 1'b1;
    iss(OP_LOAD, 9, 0, 10, 1'b0, 0);
    vld = 1'b0;
    abt = 1'b1;
    @(posedge clk);
    #1;
    chk({dab, req, wbv}, 3'b100);
    abt = 1'b0;
    stall = 1'b0;
    settle;
    chk(wbv, 1'b0);
  endtask

  task automatic t_muldiv;
    sg = 1'b0;
    alu(OP_ADD, 0, 0, 11, 1'b1, 32'h0001_0000, 32'h0001_0000);
    alu(OP_ADD, 0, 0, 12, 1'b1, 3, 3);
    iss(OP_MULT, 12, 12, 0, 1'b0, 0);
    iss(OP_MULT, 11, 12, 0, 1'b0, 0);
    chk(nw, 0);
    iss(OP_MULT, 11, 11, 0, 1'b0, 0);
    iss(OP_MULT, 11, 11, 0, 1'b0, 0);
    chk(nw, 1);
    alu(OP_MFHI, 0, 0, 13, 1'b0, 0, 1);
    alu(OP_MFLO, 0, 0, 13, 1'b0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      v = dv[i];
      alu(OP_ADD, 0, 0, 14, 1'b1, v, v);
      iss(OP_DIV, 14, 12, 0, 1'b0, 0);
      alu(OP_MFLO, 0, 0, 15, 1'b0, 0, v / 3);
      chk(nw, st[i]);
      alu(OP_MFHI, 0, 0, 15, 1'b0, 0, v % 3);
    end
    sg = 1'b1;
    alu(OP_ADD, 0, 0, 14, 1'b1, -100, -100);
    iss(OP_DIV, 14, 12, 0, 1'b0, 0);
    alu(OP_MFLO, 0, 0, 15, 1'b0, 0, -33);
    alu(OP_MFHI, 0, 0, 15, 1'b0, 0, -1);
  endtask

  initial begin
    {rst, en, vld, ui, sg, abt, stall} = 7'b1100000;
    op = OP_ADD;
    sz = SZ_WORD;
    {rs, rt, rd, imm, dly} = '0;
    num_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(fa, PC_RESET);
    en = 1'b0;
    @(negedge clk);
    chk(rdy, 1'b0);
    @(posedge clk);
    #1;
    en = 1'b1;
    t_alu;
    t_br;
    t_mem;
    t_muldiv;
    settle;
    final_report;
  end

  initial begin
    #40000;
    num_errors++;
    final_report;
  end
endmodule // integer_execution_unit_bench

`default_nettype wire
